// ===== design/icfc_codec.sv
// Information-channel late-field encoder, decoder and rate arithmetic
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps

module icfc_codec #(
	parameter logic [2:0]  LOCAL_VER = icfc_pkg::VER_ISSUE1,
	// Arbitrary neutral maker identifier
	parameter logic [27:0] MAKER_ID  = 28'h0102030
) (
	// Clock, reset, enable
	input  wire logic                     clk,
	input  wire logic                     resetn,
	input  wire logic                     clk_en,
	// Register bus
	input  wire icfc_pkg::icfc_axil_req_t axi_req,
	output icfc_pkg::icfc_axil_rsp_t      axi_rsp,
	// Received octet stream, octet 7 first
	input  wire logic [7:0]               rx_octet,
	input  wire logic                     rx_valid,
	input  wire logic                     rx_first,
	output logic                          rx_frame_done,
	// Transmitted octet stream
	input  wire logic                     tx_ready,
	output logic [7:0]                    tx_octet,
	output logic                          tx_valid,
	output logic                          tx_first,
	// Loopback state toward the datapath
	output logic                          loop_active
);
	import icfc_pkg::*;

	// Register state
	icfc_ctrl_t  ctrl_q;
	icfc_hdr_t   hdr_q;
	icfc_peer_t  peer_q;
	logic [31:0] txdig_q;
	logic [31:0] ratereq_q;

	// Bus state
	logic        aw_hold_q;
	logic        w_hold_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic        wr_fire;

	// Link state
	logic [3:0]  tx_idx_q;
	logic [7:0]  tx_octet_q;
	logic        tx_valid_q;
	logic        tx_first_q;
	logic [7:0]  tx_frame_q [0:9];
	logic [7:0]  tx_build [0:9];
	logic [3:0]  tx_dig [0:6];
	logic        cause_ok;
	logic [3:0]  rx_idx_q;
	logic [7:0]  rx_buf_q [0:9];
	logic        rx_done_q;
	logic        rx_upd_q;

	// Decoded receive state
	logic        rx_new_q;
	logic [22:0] rx_stat_q;
	logic [5:0]  rx_sub_q;
	logic [5:0]  rx_xsel_q;
	logic [27:0] rx_dig_q;
	logic [2:0]  rx_cnt;
	logic        rx_bad;
	logic [2:0]  agreed_ver;

	// Rate results
	logic [5:0]  tx_rm_q;
	logic [2:0]  tx_sm_q;
	logic [6:0]  tx_n_q;
	logic [22:0] rx_a_q;
	logic [6:0]  rx_n_q;
	logic [8:0]  split;

	// Bearer rate from the select bit
	function automatic logic [31:0] base_bps(input logic b);
		return b ? BASE64_BPS : BASE56_BPS;
	endfunction

	// Application rate from multipliers
	function automatic logic [31:0] app_rate(input logic [2:0] m,
		input logic b, input logic [5:0] rm, input logic [2:0] sm);
		logic [31:0] base;
		base = {26'h0, rm} * base_bps(b);
		case (m)
			MODE0, MODE1: return base;
			// Exact: every bearer rate divides by 64
			MODE2: return (base * EFF_NUM) >> EFF_SHIFT;
			MODE3: return base + {29'h0, sm} * SUB_STEP_BPS;
			default: return 32'h0;
		endcase
	endfunction

	// Channel count; Mode 3 rounds up over 63/64 rate
	function automatic logic [6:0] chan_count(input logic [2:0] m,
		input logic b, input logic [5:0] rm, input logic [2:0] sm);
		logic [31:0] eff63;
		logic [31:0] q;
		eff63 = EFF_NUM * base_bps(b);
		q = ((app_rate(m, b, rm, sm) << EFF_SHIFT) + eff63 - 32'd1)
			/ eff63;
		case (m)
			MODE0, MODE1, MODE2: return {1'b0, rm};
			MODE3: return q[6:0];
			default: return 7'h0;
		endcase
	endfunction

	// Multipliers from a requested rate, saturating at 63
	function automatic logic [8:0] rate_split(input logic [2:0] m,
		input logic b, input logic [31:0] a);
		logic [31:0] q;
		logic [31:0] rem;
		logic [5:0]  rm;
		if (m == MODE2)
			q = (a << EFF_SHIFT) / (EFF_NUM * base_bps(b));
		else
			q = a / base_bps(b);
		rm = (q > {26'h0, MUL_MAX}) ? MUL_MAX : q[5:0];
		rem = (a - {26'h0, rm} * base_bps(b)) / SUB_STEP_BPS;
		if (m == MODE3)
			return {rm, rem[2:0]};
		else
			return {rm, SUB_UNUSED};
	endfunction

	// Byte-enable merge
	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (s[i])
				r[8*i +: 8] = d[8*i +: 8];
		return r;
	endfunction

	// Bus handshakes; a write runs once both halves are held
	assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
	assign axi_rsp.awready = !aw_hold_q && !bvalid_q;
	assign axi_rsp.wready  = !w_hold_q && !bvalid_q;
	assign axi_rsp.bvalid  = bvalid_q;
	assign axi_rsp.bresp   = bresp_q;
	assign axi_rsp.arready = !rvalid_q;
	assign axi_rsp.rvalid  = rvalid_q;
	assign axi_rsp.rdata   = rdata_q;
	assign axi_rsp.rresp   = rresp_q;

	// Write channel capture and response
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else if (clk_en) begin
			if (axi_req.awvalid && axi_rsp.awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q  <= axi_req.awaddr;
			end
			if (axi_req.wvalid && axi_rsp.wready) begin
				w_hold_q <= 1'b1;
				wdata_q  <= axi_req.wdata;
				wstrb_q  <= axi_req.wstrb;
			end
			if (wr_fire) begin
				aw_hold_q <= 1'b0;
				w_hold_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				// Read-only words accept writes silently
				bresp_q <= ({awaddr_q[7:2], 2'b00} <= OFS_RXRATE)
					? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && axi_req.bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Software-written registers
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn) begin
			ctrl_q    <= REG_RST;
			hdr_q     <= REG_RST;
			peer_q    <= REG_RST;
			txdig_q   <= REG_RST;
			ratereq_q <= REG_RST;
		end else if (clk_en && wr_fire) begin
			case ({awaddr_q[7:2], 2'b00})
				OFS_CTRL: ctrl_q <= wmerge(ctrl_q, wdata_q, wstrb_q)
					& CTRL_WMASK;
				OFS_HDR: hdr_q <= wmerge(hdr_q, wdata_q, wstrb_q)
					& HDR_WMASK;
				OFS_TXDIG: txdig_q <= wmerge(txdig_q, wdata_q, wstrb_q)
					& DIG_WMASK;
				OFS_RATEREQ: ratereq_q <= wmerge(ratereq_q, wdata_q,
					wstrb_q) & RATE_WMASK;
				OFS_PEER: peer_q <= wmerge(peer_q, wdata_q, wstrb_q)
					& PEER_WMASK;
				default: ;
			endcase
		end
	end

	// Read channel; unmapped words answer with an error
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0;
			rresp_q  <= RESP_OKAY;
		end else if (clk_en) begin
			if (axi_req.arvalid && !rvalid_q) begin
				rvalid_q <= 1'b1;
				rresp_q  <= RESP_OKAY;
				case ({axi_req.araddr[7:2], 2'b00})
					OFS_CTRL:    rdata_q <= ctrl_q;
					OFS_HDR:     rdata_q <= hdr_q;
					OFS_TXDIG:   rdata_q <= txdig_q;
					OFS_RATEREQ: rdata_q <= ratereq_q;
					OFS_PEER:    rdata_q <= peer_q;
					OFS_TXRATE:  rdata_q <= {9'h0, tx_n_q, 5'h0,
						tx_sm_q, 2'h0, tx_rm_q};
					OFS_RXSTAT:  rdata_q <= {8'h0, rx_stat_q,
						rx_new_q};
					OFS_RXADDR:  rdata_q <= {18'h0, rx_xsel_q, 2'h0,
						rx_sub_q};
					OFS_RXDIG:   rdata_q <= {4'h0, rx_dig_q};
					OFS_RXRATE:  rdata_q <= {1'b0, rx_n_q, 1'b0,
						rx_a_q};
					default:
					begin
						rdata_q <= 32'h0;
						rresp_q <= RESP_SLVERR;
					end
				endcase
			end else if (rvalid_q && axi_req.rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// Cause allowed only in negotiation without numbers or id
	assign cause_ok = ctrl_q.cause_en && (hdr_q.chidx == 6'h0)
		&& !ctrl_q.maker && (ctrl_q.digit_count == 3'h0);

	// Outgoing octets 7 to 16
	always_comb
	begin
		for (int k = 0; k < NUM_DIGITS; k++) begin
			if (hdr_q.chidx != 6'h0)
				tx_dig[k] = txdig_q[27-4*k -: 4];
			else if (ctrl_q.maker)
				tx_dig[k] = MAKER_ID[27-4*k -: 4];
			else if (cause_ok)
				tx_dig[k] = (k == 0) ? DIG_CAUSE : DIG_END;
			else if (k < ctrl_q.digit_count)
				tx_dig[k] = txdig_q[27-4*k -: 4];
			else
				tx_dig[k] = DIG_END;
		end
		tx_build[0] = {1'b1, ctrl_q.eq_done,
			ctrl_q.loop_req,
			ctrl_q.loop_en,
			ctrl_q.ver_unused ? VER_UNUSED : LOCAL_VER,
			1'b1};
		tx_build[1] = {1'b1, hdr_q.subaddr, 1'b1};
		tx_build[2] = {1'b1, hdr_q.xsel, 1'b1};
		for (int k = 0; k < NUM_DIGITS; k++)
			tx_build[3+k] = {3'b111, tx_dig[k], 1'b1};
		// Rate fields are untouched, so add/delete can carry it
		if (cause_ok)
			tx_build[4] = {1'b1, ctrl_q.cause, 1'b1};
	end

	// Transmit sequencer; frame snapshot avoids mid-frame tearing
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn) begin
			tx_idx_q   <= 4'h0;
			tx_octet_q <= 8'hff;
			tx_valid_q <= 1'b0;
			tx_first_q <= 1'b0;
			tx_frame_q <= '{default: 8'hff};
		end else if (clk_en) begin
			tx_valid_q <= tx_ready;
			if (tx_ready) begin
				tx_first_q <= (tx_idx_q == 4'h0);
				if (tx_idx_q == 4'h0) begin
					tx_frame_q <= tx_build;
					tx_octet_q <= tx_build[0];
				end else begin
					tx_octet_q <= tx_frame_q[tx_idx_q];
				end
				tx_idx_q <= (tx_idx_q == FRAME_LAST) ? 4'h0
					: tx_idx_q + 4'h1;
			end
		end
	end

	assign tx_octet    = tx_octet_q;
	assign tx_valid    = tx_valid_q;
	assign tx_first    = tx_first_q;
	assign loop_active = ctrl_q.loop_en;

	// Receive collection; stray octets wait for a first marker
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn) begin
			rx_idx_q  <= FRAME_OCT;
			rx_buf_q  <= '{default: 8'hff};
			rx_done_q <= 1'b0;
			rx_upd_q  <= 1'b0;
		end else if (clk_en) begin
			rx_done_q <= rx_valid && !rx_first
				&& (rx_idx_q == FRAME_LAST);
			rx_upd_q  <= rx_done_q;
			if (rx_valid && rx_first) begin
				rx_buf_q[0] <= rx_octet;
				rx_idx_q    <= 4'h1;
			end else if (rx_valid && (rx_idx_q < FRAME_OCT)) begin
				rx_buf_q[rx_idx_q] <= rx_octet;
				rx_idx_q <= rx_idx_q + 4'h1;
			end
		end
	end

	assign rx_frame_done = rx_upd_q;

	// Received digit count and reserved-code check
	always_comb
	begin
		rx_cnt = 3'd7;
		rx_bad = 1'b0;
		for (int k = NUM_DIGITS - 1; k >= 0; k--) begin
			if (rx_buf_q[3+k][4:1] == DIG_END)
				rx_cnt = k[2:0];
		end
		for (int k = 0; k < NUM_DIGITS; k++) begin
			if ((k < rx_cnt) && (rx_buf_q[3+k][4:1] == DIG_RSVD))
				rx_bad = 1'b1;
		end
	end

	// Lower revision wins; an unused field keeps our own
	assign agreed_ver = (rx_buf_q[0][3:1] == VER_UNUSED) ? LOCAL_VER
		: (rx_buf_q[0][3:1] < LOCAL_VER) ? rx_buf_q[0][3:1]
		: LOCAL_VER;

	// Decoded fields latch once per complete frame
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn) begin
			rx_stat_q <= 23'h0;
			rx_sub_q  <= 6'h0;
			rx_xsel_q <= 6'h0;
			rx_dig_q  <= 28'h0;
		end else if (clk_en && rx_done_q) begin
			rx_stat_q[0] <= rx_buf_q[0][5];
			rx_stat_q[1] <= rx_buf_q[0][4];
			rx_stat_q[2] <= rx_buf_q[0][3:1] != VER_UNUSED;
			rx_stat_q[5:3] <= rx_buf_q[0][3:1];
			rx_stat_q[8:6] <= agreed_ver;
			// Negotiation digits only with index zero
			rx_stat_q[9] <= (peer_q.chidx == 6'h0) && !peer_q.maker
				&& (rx_buf_q[3][4:1] == DIG_CAUSE);
			rx_stat_q[10] <= (rx_buf_q[4][6:1] != 6'h0)
				&& (rx_buf_q[4][6:1] <= CAUSE_MAX_DEF);
			rx_stat_q[16:11] <= rx_buf_q[4][6:1];
			rx_stat_q[17] <= (peer_q.chidx == 6'h0) && !peer_q.maker;
			rx_stat_q[18] <= (peer_q.chidx == 6'h0)
				&& peer_q.maker;
			rx_stat_q[21:19] <= rx_cnt;
			rx_stat_q[22] <= rx_bad;
			rx_sub_q  <= rx_buf_q[1][6:1];
			rx_xsel_q <= rx_buf_q[2][6:1];
			for (int k = 0; k < NUM_DIGITS; k++)
				rx_dig_q[27-4*k -: 4] <= rx_buf_q[3+k][4:1];
		end
	end

	// New-frame flag: a frame in the clearing cycle wins
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			rx_new_q <= 1'b0;
		else if (clk_en) begin
			if (rx_done_q)
				rx_new_q <= 1'b1;
			else if (wr_fire && ({awaddr_q[7:2], 2'b00} == OFS_RXSTAT)
				&& wstrb_q[0] && wdata_q[RXSTAT_NEW])
				rx_new_q <= 1'b0;
		end
	end

	assign split = rate_split(hdr_q.mode, hdr_q.rsel, ratereq_q);

	// Rate arithmetic, refreshed every enabled cycle
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn) begin
			tx_rm_q <= 6'h0;
			tx_sm_q <= 3'h0;
			tx_n_q  <= 7'h0;
			rx_a_q  <= 23'h0;
			rx_n_q  <= 7'h0;
		end else if (clk_en) begin
			tx_rm_q <= split[8:3];
			tx_sm_q <= split[2:0];
			tx_n_q  <= chan_count(hdr_q.mode, hdr_q.rsel,
				split[8:3], split[2:0]);
			// Largest rate fits 23 bits, so the cut loses nothing
			rx_a_q  <= 23'(app_rate(peer_q.mode, peer_q.rsel,
				peer_q.mul, peer_q.sub_mul));
			rx_n_q  <= chan_count(peer_q.mode, peer_q.rsel,
				peer_q.mul, peer_q.sub_mul);
		end
	end

endmodule // icfc_codec

// ===== design/icfc_pkg.sv
// Package: constants, register layouts and bus carriers of the field codec
package icfc_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_HDR     = 8'h04;
	localparam logic [7:0] OFS_TXDIG   = 8'h08;
	localparam logic [7:0] OFS_RATEREQ = 8'h0c;
	localparam logic [7:0] OFS_PEER    = 8'h10;
	localparam logic [7:0] OFS_TXRATE  = 8'h14;
	localparam logic [7:0] OFS_RXSTAT  = 8'h18;
	localparam logic [7:0] OFS_RXADDR  = 8'h1c;
	localparam logic [7:0] OFS_RXDIG   = 8'h20;
	localparam logic [7:0] OFS_RXRATE  = 8'h24;

	// Writable bits per register; the rest read as zero
	localparam logic [31:0] CTRL_WMASK = 32'h003f_073f;
	localparam logic [31:0] HDR_WMASK  = 32'h3f3f_3f0f;
	localparam logic [31:0] DIG_WMASK  = 32'h0fff_ffff;
	localparam logic [31:0] RATE_WMASK = 32'h007f_ffff;
	localparam logic [31:0] PEER_WMASK = 32'hbf07_3f0f;
	localparam logic [31:0] REG_RST    = 32'h0000_0000;
	localparam int          RXSTAT_NEW = 0;

	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Operating mode codes
	localparam logic [2:0] MODE0    = 3'b000;
	localparam logic [2:0] MODE1    = 3'b001;
	localparam logic [2:0] MODE2    = 3'b010;
	localparam logic [2:0] MODE3    = 3'b011;
	localparam logic [2:0] MODE_NEG = 3'b111;

	// Rates in bit/s and the 63/64 overhead scaling
	localparam logic [31:0] BASE64_BPS   = 32'd64000;
	localparam logic [31:0] BASE56_BPS   = 32'd56000;
	localparam logic [31:0] SUB_STEP_BPS = 32'd8000;
	localparam logic [31:0] EFF_NUM      = 32'd63;
	localparam int          EFF_SHIFT    = 6;
	localparam logic [5:0]  MUL_MAX      = 6'd63;
	localparam logic [2:0]  SUB_UNUSED   = 3'b111;

	// Digit codes
	localparam logic [3:0] DIG_NINE  = 4'h9;
	localparam logic [3:0] DIG_END   = 4'hc;
	localparam logic [3:0] DIG_RSVD  = 4'hd;
	localparam logic [3:0] DIG_CAUSE = 4'he;
	localparam logic [3:0] DIG_PAD   = 4'hf;

	// Cause, revision, frame geometry
	localparam logic [5:0] CAUSE_MAX_DEF = 6'd13;
	localparam logic [2:0] VER_UNUSED    = 3'b111;
	localparam logic [2:0] VER_ISSUE1    = 3'h0;
	localparam logic [3:0] FRAME_OCT     = 4'd10;
	localparam logic [3:0] FRAME_LAST    = 4'd9;
	localparam int         NUM_DIGITS    = 7;

	// Control register layout
	typedef struct packed {
		logic [9:0] rsv2;
		logic [5:0] cause;
		logic [4:0] rsv1;
		logic [2:0] digit_count;
		logic [1:0] rsv0;
		logic       eq_done;
		logic       maker;
		logic       cause_en;
		logic       ver_unused;
		logic       loop_req;
		logic       loop_en;
	} icfc_ctrl_t;

	// Local header layout
	typedef struct packed {
		logic [1:0] rsv3;
		logic [5:0] chidx;
		logic [1:0] rsv2;
		logic [5:0] xsel;
		logic [1:0] rsv1;
		logic [5:0] subaddr;
		logic [3:0] rsv0;
		logic       rsel;
		logic [2:0] mode;
	} icfc_hdr_t;

	// Peer header layout, filled from earlier received octets
	typedef struct packed {
		logic       maker;
		logic       rsv3;
		logic [5:0] chidx;
		logic [4:0] rsv2;
		logic [2:0] sub_mul;
		logic [1:0] rsv1;
		logic [5:0] mul;
		logic [3:0] rsv0;
		logic       rsel;
		logic [2:0] mode;
	} icfc_peer_t;

	// AXI4-Lite request and answer
	typedef struct packed {
		logic [7:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [7:0]  araddr;
		logic        arvalid;
		logic        rready;
	} icfc_axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} icfc_axil_rsp_t;

endpackage

// ===== dv/icfc_codec_assertions.sv
// Checker: bus answers and octet-stream timing of the field codec
`timescale 1ns/1ps
module icfc_codec_assertions (
	// Clock and controls
	input wire logic                     clk,
	input wire logic                     resetn,
	input wire logic                     clk_en,
	// Register bus
	input wire icfc_pkg::icfc_axil_req_t axi_req,
	input wire icfc_pkg::icfc_axil_rsp_t axi_rsp,
	// Octet streams and loop state
	input wire logic [7:0]               rx_octet,
	input wire logic                     rx_valid,
	input wire logic                     rx_first,
	input wire logic                     rx_frame_done,
	input wire logic                     tx_ready,
	input wire logic [7:0]               tx_octet,
	input wire logic                     tx_valid,
	input wire logic                     tx_first,
	input wire logic                     loop_active
);
	import icfc_pkg::*;

	logic [3:0] tpos_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// Outgoing octet position; frozen cycles would double count
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			tpos_q <= 4'h0;
		else if (tx_valid && clk_en)
			tpos_q <= tx_first ? 4'h1 : tpos_q + 4'h1;

	// Both write halves taken at one edge
	sequence s_wr_taken;
		clk_en && axi_req.awvalid && axi_rsp.awready
			&& axi_req.wvalid && axi_rsp.wready;
	endsequence

	property p_wr_answer;
		s_wr_taken |-> ##2 axi_rsp.bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer)
		else $error("write answer not two cycles after request");

	property p_b_stands;
		axi_rsp.bvalid && !axi_req.bready |=>
			axi_rsp.bvalid && $stable(axi_rsp.bresp);
	endproperty
	a_b_stands: assert property (p_b_stands)
		else $error("write answer dropped early");

	property p_rd_answer;
		clk_en && axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read answer late");

	property p_r_stands;
		axi_rsp.rvalid && !axi_req.rready |=>
			axi_rsp.rvalid && $stable(axi_rsp.rdata);
	endproperty
	a_r_stands: assert property (p_r_stands)
		else $error("read data dropped early");

	property p_tx_answer;
		clk_en && tx_ready |=> tx_valid;
	endproperty
	a_tx_answer: assert property (p_tx_answer)
		else $error("octet not delivered one cycle after request");

	property p_tx_mark;
		tx_valid |-> tx_octet[7];
	endproperty
	a_tx_mark: assert property (p_tx_mark)
		else $error("leading octet bit not one");

	property p_tx_loop;
		tx_valid && tx_first |-> tx_octet[4] == $past(loop_active);
	endproperty
	a_tx_loop: assert property (p_tx_loop)
		else $error("loop indication differs from loop state");

	property p_tx_cycle;
		tx_valid && clk_en |->
			tx_first == (tpos_q == 4'h0 || tpos_q == 4'ha);
	endproperty
	a_tx_cycle: assert property (p_tx_cycle)
		else $error("frame start not every ten octets");

	property p_rx_done;
		rx_frame_done |-> $past(rx_valid, 2) && !$past(rx_frame_done);
	endproperty
	a_rx_done: assert property (p_rx_done)
		else $error("frame done not two cycles after last octet");

endmodule // icfc_codec_assertions

bind icfc_codec icfc_codec_assertions i_icfc_codec_assertions (
	.clk(clk), .resetn(resetn), .clk_en(clk_en),
	.axi_req(axi_req), .axi_rsp(axi_rsp),
	.rx_octet(rx_octet), .rx_valid(rx_valid), .rx_first(rx_first),
	.rx_frame_done(rx_frame_done), .tx_ready(tx_ready),
	.tx_octet(tx_octet), .tx_valid(tx_valid), .tx_first(tx_first),
	.loop_active(loop_active)
);

// ===== dv/icfc_codec_tb.sv
// Testbench: register, frame and rate checks of the field codec
`timescale 1ns/1ps
module icfc_codec_tb;
	import icfc_pkg::*;

	logic           clk;
	logic           resetn;
	logic           clk_en;
	icfc_axil_req_t req;
	icfc_axil_rsp_t rsp;
	logic [7:0]     rx_octet;
	logic           rx_valid;
	logic           rx_first;
	logic           rx_frame_done;
	logic           tx_ready;
	logic [7:0]     tx_octet;
	logic           tx_valid;
	logic           tx_first;
	logic           loop_active;
	logic [31:0]    rd_q;
	logic [1:0]     rs;
	logic [7:0]     ex [10];
	logic [7:0]     fr [10];
	logic [31:0]    hv [5];
	logic [31:0]    av [5];
	logic [31:0]    ev [5];
	int             fails;
	int             n_tests;
	int             i;

	// Maker value is arbitrary
	icfc_codec #(.MAKER_ID(28'h1234567)) i_icfc_codec (
		.clk(clk), .resetn(resetn), .clk_en(clk_en),
		.axi_req(req), .axi_rsp(rsp),
		.rx_octet(rx_octet), .rx_valid(rx_valid), .rx_first(rx_first),
		.rx_frame_done(rx_frame_done), .tx_ready(tx_ready),
		.tx_octet(tx_octet), .tx_valid(tx_valid), .tx_first(tx_first),
		.loop_active(loop_active)
	);

	icfc_peer i_icfc_peer (
		.clk(clk), .rx_octet(rx_octet), .rx_valid(rx_valid),
		.rx_first(rx_first), .tx_ready(tx_ready), .tx_octet(tx_octet),
		.tx_valid(tx_valid), .tx_first(tx_first)
	);

	// 20 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic close_out;
		$display("fails=%0d n_tests=%0d", fails, n_tests);
		if (fails == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask

	// One bus transfer; pre-edge readies decide what was taken
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int  n;
		logic ok;
		@(posedge clk);
		if (w)
		begin
			req.awaddr <= a;
			req.wdata <= d;
			req.wstrb <= 4'hf;
			req.awvalid <= 1'b1;
			req.wvalid <= 1'b1;
			req.bready <= 1'b1;
		end
		else
		begin
			req.araddr <= a;
			req.arvalid <= 1'b1;
			req.rready <= 1'b1;
		end
		ok = 1'b0;
		for (n = 0; n < 100 && !ok; n++)
		begin
			@(posedge clk);
			ok = w ? rsp.bvalid : rsp.rvalid;
			if (rsp.awready)
				req.awvalid <= 1'b0;
			if (rsp.wready)
				req.wvalid <= 1'b0;
			if (rsp.arready)
				req.arvalid <= 1'b0;
		end
		rd_q = rsp.rdata;
		rs = w ? rsp.bresp : rsp.rresp;
		req.bready <= 1'b0;
		req.rready <= 1'b0;
		if (!ok)
		begin
			fails++;
			close_out();
		end
	endtask

	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(nm, rd_q, exp);
	endtask

	task automatic wchk(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		bus(1'b1, a, d);
		chk("bresp", 32'(rs), 32'(r));
	endtask

	task automatic txchk(input int gap);
		i_icfc_peer.pull(10, gap);
		for (int k = 0; k < 10; k++)
			chk("tx octet", 32'(i_icfc_peer.cap[k]), 32'(ex[k]));
	endtask

	// Frame in, then a bounded wait for the done pulse
	task automatic rxgo(input int gap);
		int n;
		i_icfc_peer.send(fr, gap);
		for (n = 0; n < 20 && rx_frame_done !== 1'b1; n++)
			@(posedge clk);
		chk("frame done", 32'(n < 20), 32'h1);
		if (n >= 20)
			close_out();
	endtask

	initial
	begin
		fails = 0;
		n_tests = 0;
		resetn = 1'b0;
		clk_en = 1'b1;
		req = '0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		// Reset state, masked bits, refused offsets
		rchk("ctrl", OFS_CTRL, 32'h0);
		chk("loop", 32'(loop_active), 32'h0);
		wchk(OFS_CTRL, 32'hffff_ffff, RESP_OKAY);
		rchk("ctrl", OFS_CTRL, 32'h003f_073f);
		chk("loop", 32'(loop_active), 32'h1);
		rchk("gap", 8'h28, 32'h0);
		chk("rresp", 32'(rs), 32'(RESP_SLVERR));
		wchk(8'h28, 32'h1, RESP_SLVERR);
		// Short number with loopback asked and active
		wchk(OFS_HDR, 32'h0005_3f08, RESP_OKAY);
		wchk(OFS_TXDIG, 32'h0123_9999, RESP_OKAY);
		wchk(OFS_CTRL, 32'h0000_0303, RESP_OKAY);
		ex = '{8'hb1, 8'hff, 8'h8b, 8'he3, 8'he5,
			8'he7, 8'hf9, 8'hf9, 8'hf9, 8'hf9};
		txchk(0);
		// Full number, revision unused, loop off
		wchk(OFS_CTRL, 32'h0000_0704, RESP_OKAY);
		ex[0] = 8'h8f;
		for (i = 6; i < 10; i++)
			ex[i] = 8'hf3;
		txchk(1);
		// Maker identifier in the digit fields
		wchk(OFS_CTRL, 32'h0000_0010, RESP_OKAY);
		ex = '{8'h81, 8'hff, 8'h8b, 8'he3, 8'he5,
			8'he7, 8'he9, 8'heb, 8'hed, 8'hef};
		txchk(0);
		// Cause during negotiation, slow reader
		wchk(OFS_CTRL, 32'h0009_0008, RESP_OKAY);
		ex[3] = 8'hfd;
		ex[4] = 8'h93;
		for (i = 5; i < 10; i++)
			ex[i] = 8'hf9;
		txchk(2);
		// Nonzero channel index: digits pass untouched
		wchk(OFS_HDR, 32'h0305_3f08, RESP_OKAY);
		wchk(OFS_CTRL, 32'h0, RESP_OKAY);
		i_icfc_peer.pull(10, 0);
		chk("user", 32'(i_icfc_peer.cap[6][4:1]), 32'h9);
		// Rate split per mode and bearer rate
		hv = '{32'h8, 32'h1, 32'ha, 32'h3, 32'hb};
		av = '{32'h2ee00, 32'h1b580, 32'h2e248, 32'h2cec0, 32'h1f400};
		ev = '{32'h30703, 32'h20702, 32'h30703, 32'h40203, 32'h30002};
		for (i = 0; i < 5; i++)
		begin
			wchk(OFS_HDR, hv[i], RESP_OKAY);
			wchk(OFS_RATEREQ, av[i], RESP_OKAY);
			rchk("rate", OFS_TXRATE, ev[i]);
		end
		wchk(OFS_TXRATE, 32'hffff_ffff, RESP_OKAY);
		rchk("rate", OFS_TXRATE, ev[4]);
		// Received frame: numbers, revision, channel count
		wchk(OFS_PEER, 32'h0002_0303, RESP_OKAY);
		rchk("rxrate", OFS_RXRATE, 32'h0402_cec0);
		wchk(OFS_PEER, 32'h0002_0307, RESP_OKAY);
		rchk("rxrate", OFS_RXRATE, 32'h0);
		fr = '{8'he5, 8'h99, 8'h81, 8'heb, 8'heb,
			8'hf9, 8'hf9, 8'hf9, 8'hf9, 8'hf9};
		rxgo(0);
		rchk("rxstat", OFS_RXSTAT, 32'h0027_502b);
		rchk("rxaddr", OFS_RXADDR, 32'h0000_000c);
		rchk("rxdig", OFS_RXDIG, 32'h055c_cccc);
		wchk(OFS_RXSTAT, 32'h1, RESP_OKAY);
		rchk("rxstat", OFS_RXSTAT, 32'h0027_502a);
		// Frozen enable: a whole frame must leave no trace
		clk_en <= 1'b0;
		i_icfc_peer.send(fr, 0);
		repeat (3) @(posedge clk);
		chk("frozen", 32'(rx_frame_done), 32'h0);
		clk_en <= 1'b1;
		rchk("rxstat", OFS_RXSTAT, 32'h0027_502a);
		// Reserved cause, unused revision, spaced octets
		fr = '{8'h9f, 8'h81, 8'h81, 8'hfd, 8'h9d,
			8'hf9, 8'hf9, 8'hf9, 8'hf9, 8'hf9};
		rxgo(1);
		bus(1'b0, OFS_RXSTAT, 32'h0);
		chk("rxstat", rd_q & 32'h0003_ff8d, 32'h0000_e405);
		close_out();
	end

endmodule // icfc_codec_tb

// ===== dv/icfc_peer.sv
// Peer endpoint model: feeds frames in and collects outgoing frames
`timescale 1ns/1ps
module icfc_peer (
	// Clock
	input wire logic       clk,
	// Toward the codec receiver
	output logic [7:0]     rx_octet,
	output logic           rx_valid,
	output logic           rx_first,
	// From the codec transmitter
	output logic           tx_ready,
	input wire logic [7:0] tx_octet,
	input wire logic       tx_valid,
	input wire logic       tx_first
);
	logic [7:0] cap [10];
	int         pos = 0;

	// Quiet lines at start
	initial
	begin
		rx_octet = 8'h00;
		rx_valid = 1'b0;
		rx_first = 1'b0;
		tx_ready = 1'b0;
	end

	// Capture restarts on each frame start
	always @(posedge clk)
		if (tx_valid)
		begin
			if (tx_first)
				pos = 0;
			if (pos < 10)
				cap[pos] = tx_octet;
			pos++;
		end

	// Released line shows the inverse, never a stale value
	task automatic send(input logic [7:0] f [10], input int gap);
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk);
			rx_octet <= f[i];
			rx_valid <= 1'b1;
			rx_first <= (i == 0);
			if (gap > 0)
			begin
				@(posedge clk);
				rx_valid <= 1'b0;
				rx_first <= 1'b0;
				rx_octet <= ~f[i];
				repeat (gap - 1) @(posedge clk);
			end
		end
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_first <= 1'b0;
		rx_octet <= ~f[9];
	endtask

	// Asks for octets promptly or with idle gaps
	task automatic pull(input int n, input int gap);
		repeat (n)
		begin
			@(posedge clk);
			tx_ready <= 1'b1;
			if (gap > 0)
			begin
				@(posedge clk);
				tx_ready <= 1'b0;
				repeat (gap - 1) @(posedge clk);
			end
		end
		@(posedge clk);
		tx_ready <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

endmodule // icfc_peer
